// ==== core/bridge_header_bus_io_window_regs.sv ====
// Bridge header slice: layout byte, switch register window, bus numbers, I/O window and forwarding check.
// Assumes a configuration agent on the same clock issuing one-cycle dword read and write strobes.
//
// Contract
// - Layout field bits 22:16 always read 01h.
// - Bit 23 reads 1 upstream, 0 downstream.
// - Window base bits 0 and 3 read zero.
// - Both window base registers only on upstream.
// - Base bits 31:17 writable, bits 16:4 zero.
// - High base read-only unless type is 10b.
// - High base fully writable in 64-bit mode, reset zero.
// - Primary bus number byte writable, reset 00h.
// - Secondary bus number byte writable, reset 00h.
// - Subordinate bus number byte writable, reset 00h.
// - I/O base and limit low nibbles read 1h.
// - I/O bottom address bits 15:12 writable, rest zero.
// - I/O top address bits 15:12 writable, rest ones.
// - Forward I/O only inside the programmed window.
// - I/O upper 16 bits come from extension inputs.
// - Latency byte reserved, always reads 00h.
`timescale 1ns/1ps
module bridge_header_bus_io_window_regs
  import bridge_hdr_pkg::*;
#(
  parameter bit WIN_64BIT = 1'b0
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Port role, static while out of reset
  input  wire logic        is_upstream,
  // Configuration access
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic [31:0]      cfg_rdata,
  output logic             cfg_rd_valid,
  // Upper halves of the I/O window from the extension registers
  input  wire logic [15:0] io_bottom_upper,
  input  wire logic [15:0] io_top_upper,
  // I/O forwarding check
  input  wire logic        io_req_valid,
  input  wire logic [31:0] io_req_addr,
  output logic             io_fwd_valid,
  output logic             io_fwd_hit,
  // Programmed values seen by the rest of the port
  output logic [7:0]       primary_bus,
  output logic [7:0]       secondary_bus,
  output logic [7:0]       subordinate_bus,
  output logic [63:0]      switch_window_base
);

  localparam logic [1:0] ADDR_TYPE = WIN_64BIT ? ADDR_TYPE_64 : ADDR_TYPE_32;

  logic [14:0] win_addr_q;
  logic [31:0] win_hi_q;
  logic [7:0]  pri_bus_q;
  logic [7:0]  sec_bus_q;
  logic [7:0]  sub_bus_q;
  logic [3:0]  io_bottom_q;
  logic [3:0]  io_top_q;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;
  logic        rd_valid_q;
  logic        fwd_valid_q;
  logic        fwd_hit_q;
  logic        win_wr;
  logic        win_hi_wr;
  logic        bus_wr;
  logic        io_wr;
  logic        hi_writable;
  logic [31:0] io_bottom_addr;
  logic [31:0] io_top_addr;
  logic        io_hit;

  // Address decode; the base registers vanish on downstream ports.
  assign win_wr      = cfg_wr && is_upstream && (cfg_addr == OFF_WIN_BASE_LO);
  assign hi_writable = (ADDR_TYPE == ADDR_TYPE_64);
  assign win_hi_wr   = cfg_wr && is_upstream && hi_writable && (cfg_addr == OFF_WIN_BASE_HI);
  assign bus_wr      = cfg_wr && (cfg_addr == OFF_BUS_NUMBERS);
  assign io_wr       = cfg_wr && (cfg_addr == OFF_IO_WINDOW);

  // Only bits 31:17 of the low base hold state; bits 23:17 sit in byte lane 2.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_addr_q <= WIN_ADDR_RESET;
    end else if (win_wr) begin
      if (cfg_be[2]) begin
        win_addr_q[6:0] <= cfg_wdata[23:WIN_ADDR_LSB];
      end
      if (cfg_be[3]) begin
        win_addr_q[14:7] <= cfg_wdata[31:24];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      win_hi_q <= WIN_BASE_HI_RESET;
    end else if (win_hi_wr) begin
      for (int b = 0; b < 4; b++) begin
        if (cfg_be[b]) begin
          win_hi_q[b*8 +: 8] <= cfg_wdata[b*8 +: 8];
        end
      end
    end
  end

  // Bus numbers; lane 3 is the reserved latency byte and is dropped.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pri_bus_q <= BUS_NUM_RESET;
      sec_bus_q <= BUS_NUM_RESET;
      sub_bus_q <= BUS_NUM_RESET;
    end else if (bus_wr) begin
      if (cfg_be[0]) begin
        pri_bus_q <= cfg_wdata[7:0];
      end
      if (cfg_be[1]) begin
        sec_bus_q <= cfg_wdata[15:8];
      end
      if (cfg_be[2]) begin
        sub_bus_q <= cfg_wdata[23:16];
      end
    end
  end

  // I/O window nibbles; the capability nibbles beside them hold no state.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      io_bottom_q <= IO_ADDR_RESET;
      io_top_q    <= IO_ADDR_RESET;
    end else if (io_wr) begin
      if (cfg_be[0]) begin
        io_bottom_q <= cfg_wdata[7:4];
      end
      if (cfg_be[1]) begin
        io_top_q <= cfg_wdata[15:12];
      end
    end
  end

  // Read mux; anything outside this slice reads as zero.
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (cfg_addr == OFF_HEADER_DW) begin
      rdata_d[LAYOUT_MSB:LAYOUT_LSB] = LAYOUT_BRIDGE;
      rdata_d[MULTI_FUNC_BIT]        = is_upstream;
    end else if (cfg_addr == OFF_WIN_BASE_LO) begin
      if (is_upstream) begin
        rdata_d[SPACE_BIT]                     = 1'b0;
        rdata_d[ADDR_TYPE_MSB:ADDR_TYPE_LSB]   = ADDR_TYPE;
        rdata_d[PREFETCH_BIT]                  = 1'b0;
        rdata_d[31:WIN_ADDR_LSB]               = win_addr_q;
      end
    end else if (cfg_addr == OFF_WIN_BASE_HI) begin
      if (is_upstream) begin
        rdata_d = win_hi_q;
      end
    end else if (cfg_addr == OFF_BUS_NUMBERS) begin
      rdata_d = {LATENCY_FIXED, sub_bus_q, sec_bus_q, pri_bus_q};
    end else if (cfg_addr == OFF_IO_WINDOW) begin
      rdata_d[15:0] = {io_top_q, IO_CAP_32BIT, io_bottom_q, IO_CAP_32BIT};
    end
  end

  // A read in the same cycle as a write returns the value before the write.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rdata_q    <= 32'h0000_0000;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= cfg_rd;
      if (cfg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Full window edges: extension inputs above, programmed nibble, then fixed fill.
  assign io_bottom_addr = {io_bottom_upper, io_bottom_q, IO_BOTTOM_FILL};
  assign io_top_addr    = {io_top_upper, io_top_q, IO_TOP_FILL};

  io_window_match u_io_match (
    .bottom (io_bottom_addr),
    .top    (io_top_addr),
    .addr   (io_req_addr),
    .hit    (io_hit)
  );

  // The decision is registered so the forwarding path sees a clean flop output.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      fwd_valid_q <= 1'b0;
      fwd_hit_q   <= 1'b0;
    end else begin
      fwd_valid_q <= io_req_valid;
      fwd_hit_q   <= io_req_valid && io_hit;
    end
  end

  assign cfg_rdata          = rdata_q;
  assign cfg_rd_valid       = rd_valid_q;
  assign io_fwd_valid       = fwd_valid_q;
  assign io_fwd_hit         = fwd_hit_q;
  assign primary_bus        = pri_bus_q;
  assign secondary_bus      = sec_bus_q;
  assign subordinate_bus    = sub_bus_q;
  // Upper half is meaningful only in 64-bit mode; it stays zero otherwise.
  assign switch_window_base = {win_hi_q, win_addr_q, 17'h0_0000};

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_read(logic [7:0] off);
    cfg_rd && !cfg_wr && (cfg_addr == off);
  endsequence

  sequence s_write(logic [7:0] off, logic [3:0] be);
    cfg_wr && (cfg_addr == off) && ((cfg_be & be) == be);
  endsequence

  chk_layout_value: assert property (
    s_read(OFF_HEADER_DW) |=> cfg_rd_valid && (cfg_rdata[22:16] == 7'h01))
    else $error("layout field did not read 01h");

  chk_multi_func: assert property (
    s_read(OFF_HEADER_DW) |=> cfg_rdata[23] == $past(is_upstream))
    else $error("multi-function bit does not match port role");

  chk_base_flags: assert property (
    s_read(OFF_WIN_BASE_LO) |=> (cfg_rdata[0] == 1'b0) && (cfg_rdata[3] == 1'b0))
    else $error("base space or prefetch bit not zero");

  chk_down_nobase: assert property (
    (s_read(OFF_WIN_BASE_LO) or s_read(OFF_WIN_BASE_HI)) ##0 !is_upstream |=> cfg_rdata == 32'h0000_0000)
    else $error("downstream port shows a base register");

  chk_base_write: assert property (
    s_write(OFF_WIN_BASE_LO, 4'hC) ##0 is_upstream
    |=> win_addr_q == $past(cfg_wdata[31:17]))
    else $error("window base write not stored");

  chk_high_locked: assert property (
    cfg_wr && (cfg_addr == OFF_WIN_BASE_HI) && !hi_writable |=> $stable(win_hi_q))
    else $error("high base changed while not in 64-bit mode");

  chk_high_write: assert property (
    s_write(OFF_WIN_BASE_HI, 4'hF) ##0 (is_upstream && hi_writable) |=> win_hi_q == $past(cfg_wdata))
    else $error("high base not written in 64-bit mode");

  chk_bus_numbers: assert property (
    s_write(OFF_BUS_NUMBERS, 4'h7) |=> {sub_bus_q, sec_bus_q, pri_bus_q} == $past(cfg_wdata[23:0]))
    else $error("bus numbers not taken from write");

  chk_latency_zero: assert property (
    s_read(OFF_BUS_NUMBERS) |=> cfg_rdata[31:24] == 8'h00)
    else $error("latency byte not zero");

  chk_io_cap: assert property (
    s_read(OFF_IO_WINDOW) |=> (cfg_rdata[3:0] == 4'h1) && (cfg_rdata[11:8] == 4'h1))
    else $error("I/O capability nibbles not 1h");

  chk_io_edges: assert property (
    s_write(OFF_IO_WINDOW, 4'h3) |=> (io_bottom_addr[15:0] == {$past(cfg_wdata[7:4]), 12'h000})
      && (io_top_addr[15:0] == {$past(cfg_wdata[15:12]), 12'hFFF}))
    else $error("I/O window edges not assembled from written nibbles");

  chk_io_forward: assert property (
    io_req_valid |=> io_fwd_valid && (io_fwd_hit ==
      (($past(io_req_addr) >= $past(io_bottom_addr)) && ($past(io_req_addr) <= $past(io_top_addr)))))
    else $error("I/O forward decision outside window");

  chk_fixed_ignore: assert property (
    s_write(OFF_HEADER_DW, 4'hF) |=> $stable({win_addr_q, win_hi_q, pri_bus_q, io_bottom_q, io_top_q}))
    else $error("write to fixed header dword changed state");

  // Sampled on the first edge out of reset, before any write can have landed.
  chk_reset_values: assert property (
    $rose(rstn) |-> (win_hi_q == 32'h0000_0000) && (win_addr_q == 15'h0000)
      && ({sub_bus_q, sec_bus_q, pri_bus_q} == 24'h00_0000) && ({io_top_q, io_bottom_q} == 8'h00))
    else $error("registers not at reset values after reset");

  chk_base_read: assert property (
    s_read(OFF_WIN_BASE_LO) ##0 is_upstream |=> (cfg_rdata[31:17] == $past(switch_window_base[31:17]))
      && (cfg_rdata[16:4] == 13'h0000) && (cfg_rdata[2:1] == (WIN_64BIT ? 2'h2 : 2'h0)))
    else $error("window base read back wrong or reserved bits set");

  chk_high_fixed: assert property (
    s_read(OFF_WIN_BASE_HI) ##0 !WIN_64BIT |=> cfg_rdata == 32'h0000_0000)
    else $error("read-only high base did not read zero");

  chk_down_locked: assert property (
    cfg_wr && !is_upstream && ((cfg_addr == OFF_WIN_BASE_LO) || (cfg_addr == OFF_WIN_BASE_HI))
    |=> $stable({win_addr_q, win_hi_q}))
    else $error("downstream port stored a base register write");

  // A write that leaves a lane's enable low must not touch that byte.
  sequence s_bus_skip(int lane);
    cfg_wr && (cfg_addr == OFF_BUS_NUMBERS) && !cfg_be[lane];
  endsequence

  chk_pri_hold: assert property (
    s_bus_skip(0) |=> $stable(pri_bus_q))
    else $error("primary bus number changed without its lane");

  chk_sec_hold: assert property (
    s_bus_skip(1) |=> $stable(sec_bus_q))
    else $error("secondary bus number changed without its lane");

  chk_sub_hold: assert property (
    s_bus_skip(2) |=> $stable(sub_bus_q))
    else $error("subordinate bus number changed without its lane");

  chk_bus_other: assert property (
    cfg_wr && (cfg_addr != OFF_BUS_NUMBERS) |=> $stable({sub_bus_q, sec_bus_q, pri_bus_q}))
    else $error("bus numbers changed by a write to another dword");

  chk_io_other: assert property (
    cfg_wr && (cfg_addr != OFF_IO_WINDOW) |=> $stable({io_top_q, io_bottom_q}))
    else $error("I/O window nibbles changed by a write to another dword");

  chk_bus_read: assert property (
    s_read(OFF_BUS_NUMBERS) |=> cfg_rdata[23:0] == $past({subordinate_bus, secondary_bus, primary_bus}))
    else $error("bus number read back differs from stored values");

  chk_io_read: assert property (
    s_read(OFF_IO_WINDOW) |=> (cfg_rdata[7:4] == $past(io_bottom_q)) && (cfg_rdata[15:12] == $past(io_top_q)))
    else $error("I/O window nibbles read back wrong");

  chk_fwd_idle: assert property (
    !io_req_valid |=> !io_fwd_valid && !io_fwd_hit)
    else $error("forward decision without a request");

  // Upper halves come from the extension inputs, so a request outside them misses whatever the nibbles hold.
  chk_io_below: assert property (
    io_req_valid && (io_req_addr[31:16] < io_bottom_upper) |=> !io_fwd_hit)
    else $error("request below the upper bottom half was forwarded");

  chk_io_above: assert property (
    io_req_valid && (io_req_addr[31:16] > io_top_upper) |=> !io_fwd_hit)
    else $error("request above the upper top half was forwarded");

endmodule // bridge_header_bus_io_window_regs

// ==== core/bridge_hdr_pkg.sv ====
// Constants for the bridge header slice: offsets, field positions, reset and fixed values.
// Assumes the configuration port addresses whole dwords by byte offset.
package bridge_hdr_pkg;

  // Dword offsets of the header slice.
  localparam logic [7:0]  OFF_HEADER_DW     = 8'h0C;
  localparam logic [7:0]  OFF_WIN_BASE_LO   = 8'h10;
  localparam logic [7:0]  OFF_WIN_BASE_HI   = 8'h14;
  localparam logic [7:0]  OFF_BUS_NUMBERS   = 8'h18;
  localparam logic [7:0]  OFF_IO_WINDOW     = 8'h1C;

  // Header layout dword fields.
  localparam int          LAYOUT_LSB        = 16;
  localparam int          LAYOUT_MSB        = 22;
  localparam int          MULTI_FUNC_BIT    = 23;
  localparam logic [6:0]  LAYOUT_BRIDGE     = 7'h01;

  // Low and high base register fields.
  localparam int          SPACE_BIT         = 0;
  localparam int          ADDR_TYPE_LSB     = 1;
  localparam int          ADDR_TYPE_MSB     = 2;
  localparam int          PREFETCH_BIT      = 3;
  localparam int          WIN_ADDR_LSB      = 17;
  localparam logic [1:0]  ADDR_TYPE_32      = 2'h0;
  localparam logic [1:0]  ADDR_TYPE_64      = 2'h2;
  localparam logic [14:0] WIN_ADDR_RESET    = 15'h0000;
  localparam logic [31:0] WIN_BASE_HI_RESET = 32'h0000_0000;

  // Bus number dword fields.
  localparam logic [7:0]  BUS_NUM_RESET     = 8'h00;
  localparam logic [7:0]  LATENCY_FIXED     = 8'h00;

  // I/O window dword fields.
  localparam logic [3:0]  IO_CAP_32BIT      = 4'h1;
  localparam logic [3:0]  IO_ADDR_RESET     = 4'h0;
  localparam logic [11:0] IO_BOTTOM_FILL    = 12'h000;
  localparam logic [11:0] IO_TOP_FILL       = 12'hFFF;

endpackage

// ==== core/io_window_match.sv ====
// Inclusive address range compare used for I/O forwarding decisions.
// Assumes bottom and top are already assembled to full 32-bit addresses.
`timescale 1ns/1ps
module io_window_match (
  // Window edges
  input  wire logic [31:0] bottom,
  input  wire logic [31:0] top,
  // Address under test
  input  wire logic [31:0] addr,
  output logic             hit
);

  // A top below the bottom yields an empty window, which is how software shuts I/O forwarding off.
  assign hit = (addr >= bottom) && (addr <= top);

endmodule // io_window_match

// ==== test/cfg_host_model.sv ====
// Configuration host model issuing one-cycle dword write and read strobes.
// Assumes the bench calls its tasks and that clk is the block's clock.
`timescale 1ns/1ps
module cfg_host_model (
  // Clock
  input  wire logic        clk,
  // Request
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic [7:0]       cfg_addr,
  output logic [3:0]       cfg_be,
  output logic [31:0]      cfg_wdata,
  // Answers of the two instances
  input  wire logic [31:0] rdata_a,
  input  wire logic [31:0] rdata_b,
  input  wire logic        rd_valid
);
  initial begin
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wdata = 32'h0000_0000;
  end

  // Released lines are inverted so a stale value can never pass for a fresh one.
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(posedge clk) #1;
    cfg_wr = 1'b1;
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    @(posedge clk) #1;
    cfg_wr = 1'b0;
    cfg_addr = ~a;
    cfg_be = ~be;
    cfg_wdata = ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] da, output logic [31:0] db, output logic v);
    @(posedge clk) #1;
    cfg_rd = 1'b1;
    cfg_addr = a;
    @(posedge clk) #1;
    cfg_rd = 1'b0;
    cfg_addr = ~a;
    v = rd_valid;
    da = rdata_a;
    db = rdata_b;
  endtask
endmodule // cfg_host_model

// ==== test/test_bridge_header_bus_io_window_regs.sv ====
// Self-checking bench: 32-bit and 64-bit window builds side by side, one host model.
// Assumes a 100 MHz clock and inputs driven 1 ns after each rising edge.
`timescale 1ns/1ps
module test_bridge_header_bus_io_window_regs;
  import bridge_hdr_pkg::*;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        is_upstream = 1'b1;
  logic        io_req_valid = 1'b0;
  logic [31:0] io_req_addr = 32'h0000_0000;
  logic [15:0] bu = 16'h0000;
  logic [15:0] tu = 16'h0000;
  logic        cfg_wr, cfg_rd, valid_a, fwd_valid, fwd_hit;
  logic [7:0]  cfg_addr, pb, sb, ub;
  logic [3:0]  cfg_be;
  logic [31:0] cfg_wdata, rdata_a, rdata_b, e, bot, top, da, db;
  logic [63:0] base_a, base_b;
  logic        v, eh;
  int          miscompares = 0;
  int          total_checks = 0;
  int          cycles = 0;

  always #5 clk = ~clk;

  cfg_host_model u_host (.clk(clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .rdata_a(rdata_a), .rdata_b(rdata_b), .rd_valid(valid_a));

  bridge_header_bus_io_window_regs #(.WIN_64BIT(1'b0)) u_dut (.clk(clk), .rstn(rstn),
    .is_upstream(is_upstream), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(rdata_a), .cfg_rd_valid(valid_a), .io_bottom_upper(bu),
    .io_top_upper(tu), .io_req_valid(io_req_valid), .io_req_addr(io_req_addr), .io_fwd_valid(fwd_valid),
    .io_fwd_hit(fwd_hit), .primary_bus(pb), .secondary_bus(sb), .subordinate_bus(ub),
    .switch_window_base(base_a));

  bridge_header_bus_io_window_regs #(.WIN_64BIT(1'b1)) u_dut64 (.clk(clk), .rstn(rstn),
    .is_upstream(is_upstream), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(rdata_b), .cfg_rd_valid(), .io_bottom_upper(bu),
    .io_top_upper(tu), .io_req_valid(io_req_valid), .io_req_addr(io_req_addr), .io_fwd_valid(),
    .io_fwd_hit(), .primary_bus(), .secondary_bus(), .subordinate_bus(), .switch_window_base(base_b));

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ea, input logic [31:0] eb, input logic [31:0] m);
    u_host.rd(a, da, db, v);
    check(v, 1'b1);
    check(da & m, ea);
    check(db & m, eb);
  endtask

  task automatic rst(input logic up);
    rstn = 1'b0;
    is_upstream = up;
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
  endtask

  // Byte lane 3 holds the reserved latency byte, so only lanes 0 to 2 take data.
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [3:0] be, input logic [31:0] d);
    for (int k = 0; k < 3; k++) begin
      if (be[k]) o[8*k+:8] = d[8*k+:8];
    end
    return o;
  endfunction

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end

  initial begin
    void'($urandom(32'h8de95b19));
    rst(1'b1);
    rchk(OFF_HEADER_DW, 32'h0081_0000, 32'h0081_0000, '1);
    rchk(OFF_WIN_BASE_LO, 32'h0000_0000, 32'h0000_0004, '1);
    rchk(OFF_WIN_BASE_HI, 32'h0000_0000, 32'h0000_0000, '1);
    rchk(OFF_BUS_NUMBERS, 32'h0000_0000, 32'h0000_0000, '1);
    rchk(OFF_IO_WINDOW, 32'h0000_0101, 32'h0000_0101, 32'h0000_FFFF);
    for (int i = 0; i < 5; i++) u_host.wr(8'h0C + 8'(4 * i), 4'hF, '1);
    rchk(OFF_HEADER_DW, 32'h0081_0000, 32'h0081_0000, '1);
    rchk(OFF_WIN_BASE_LO, 32'hFFFE_0000, 32'hFFFE_0004, '1);
    rchk(OFF_WIN_BASE_HI, 32'h0000_0000, 32'hFFFF_FFFF, '1);
    rchk(OFF_BUS_NUMBERS, 32'h00FF_FFFF, 32'h00FF_FFFF, '1);
    rchk(OFF_IO_WINDOW, 32'h0000_F1F1, 32'h0000_F1F1, 32'h0000_FFFF);
    check(base_a, 64'h0000_0000_FFFE_0000);
    check(base_b, 64'hFFFF_FFFF_FFFE_0000);
    rchk(8'h20, 32'h0000_0000, 32'h0000_0000, '1);
    e = 32'h00FF_FFFF;
    for (int i = 0; i < 16; i++) begin
      da = $urandom;
      cfg_be_rand: begin
        logic [3:0] be;
        be = 4'($urandom);
        u_host.wr(OFF_BUS_NUMBERS, be, da);
        e = merge(e, be, da);
      end
      check({ub, sb, pb}, e[23:0]);
      rchk(OFF_BUS_NUMBERS, e, e, '1);
    end
    for (int i = 0; i < 12; i++) begin
      bu = 16'($urandom_range(1, 0));
      tu = 16'($urandom_range(2, 0));
      e = $urandom;
      u_host.wr(OFF_IO_WINDOW, 4'h3, {16'h0000, e[7:4], 4'h0, e[3:0], 4'h0});
      bot = {bu, e[3:0], 12'h000};
      top = {tu, e[7:4], 12'hFFF};
      for (int j = 0; j < 8; j++) begin
        case (j % 5)
          0: io_req_addr = bot;
          1: io_req_addr = bot - 32'h1;
          2: io_req_addr = top;
          3: io_req_addr = top + 32'h1;
          default: io_req_addr = {16'($urandom_range(2, 0)), 16'($urandom)};
        endcase
        eh = (io_req_addr >= bot) && (io_req_addr <= top);
        io_req_valid = 1'b1;
        @(posedge clk) #1;
        check(fwd_valid, 1'b1);
        check(fwd_hit, eh);
      end
      io_req_valid = 1'b0;
      io_req_addr = ~io_req_addr;
    end
    rst(1'b0);
    rchk(OFF_HEADER_DW, 32'h0001_0000, 32'h0001_0000, '1);
    u_host.wr(OFF_WIN_BASE_LO, 4'hF, '1);
    u_host.wr(OFF_WIN_BASE_HI, 4'hF, '1);
    rchk(OFF_WIN_BASE_LO, 32'h0000_0000, 32'h0000_0000, '1);
    rchk(OFF_WIN_BASE_HI, 32'h0000_0000, 32'h0000_0000, '1);
    summarize();
  end
endmodule // test_bridge_header_bus_io_window_regs
